// File: verilog/i2c_master_restart_tx_rx_ack.sv
// i2c master sequencer: repeated start, byte tx/rx, ack send
`timescale 1ns/1ps
module i2c_master_restart_tx_rx_ack
	import i2c_restart_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	typedef enum logic [3:0] {
		ST_IDLE, RS_PULL, RS_REL, RS_SCLH, RS_HIGH, RS_SDAL,
		BIT_LOW, BIT_WAIT, BIT_HIGH, ACK_LOW, ACK_WAIT, ACK_HIGH
	} seq_state_e;

	seq_state_e state_q;
	bus_lines_s meta_q, sync_q;
	logic sda_prev_q;
	logic [7:0] cnt_q, sh_q, buf_q, rate_q, rdata_q;
	logic [3:0] bit_q;
	logic rx_q, pend_q, ack_st_q;
	logic scl_oe_q, sda_oe_q, zero_q;
	seq_ev_s ev_q;
	logic rs_req_q, rx_req_q, ack_req_q, ack_val_q;
	logic bf_q, write_collision_flag_q, ov_q, irq_q, bcl_q, begin_q;
	logic idle, tick, ctrl_wr, buf_wr, buf_rd, stat_wr;
	logic go_rs, go_rx, go_ack, go_tx, start_seen;
	logic [7:0] load_val;

	assign idle = (state_q == ST_IDLE);
	assign tick = (cnt_q == 8'h00);
	// RULE23: rate reload
	assign load_val = rate_q[7:0];
	assign ctrl_wr = wr_i && (addr_i == CTRL_OFF);
	assign stat_wr = wr_i && (addr_i == STAT_OFF);
	assign buf_wr = wr_i && (addr_i == BUF_OFF);
	assign buf_rd = rd_i && (addr_i == BUF_OFF);
	// RULE5: only when idle
	assign go_rs = ctrl_wr && wdata_i[CTRL_RS_BIT] && idle;
	// RULE14: only when idle
	assign go_rx = ctrl_wr && wdata_i[CTRL_RX_BIT] && idle && !go_rs;
	assign go_ack = ctrl_wr && wdata_i[CTRL_ACK_BIT] && idle
		&& !go_rs && !go_rx;
	assign go_tx = buf_wr && idle;
	// RULE4: start seen on lines
	assign start_seen = sda_prev_q && !sync_q.sda && sync_q.scl;

	// two-stage line synchroniser
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_q <= '{scl: 1'b1, sda: 1'b1};
			sync_q <= '{scl: 1'b1, sda: 1'b1};
			sda_prev_q <= 1'b1;
		end else begin
			meta_q <= '{scl: scl_i, sda: sda_i};
			sync_q <= meta_q;
			sda_prev_q <= sync_q.sda;
		end
	end

	// open-drain drivers only ever pull low
	always_ff @(posedge clk_i) begin
		zero_q <= 1'b0;
	end
	assign scl_o = zero_q;
	assign sda_o = zero_q;
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;

	// sequencer
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_q <= ST_IDLE;
			cnt_q <= BYTE_RESET;
			sh_q <= BYTE_RESET;
			bit_q <= 4'h0;
			rx_q <= 1'b0;
			pend_q <= 1'b0;
			ack_st_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			ev_q <= '0;
		end else begin
			ev_q <= '0;
			if (state_q != ST_IDLE && !tick) begin
				cnt_q <= cnt_q - 8'h01;
			end
			case (state_q)
			ST_IDLE: begin
				if (go_rs) begin
					// RULE1: pull SCL low
					scl_oe_q <= 1'b1;
					state_q <= RS_PULL;
				end else if (go_rx) begin
					// RULE15: start receive clocking
					rx_q <= 1'b1;
					bit_q <= 4'h0;
					sda_oe_q <= 1'b0;
					scl_oe_q <= 1'b1;
					cnt_q <= load_val;
					state_q <= BIT_LOW;
				end else if (go_ack) begin
					// RULE19: drive ack value
					scl_oe_q <= 1'b1;
					sda_oe_q <= !ack_val_q;
					cnt_q <= load_val;
					state_q <= ACK_LOW;
				end else if (go_tx) begin
					// RULE7: buffer write starts the byte
					rx_q <= 1'b0;
					bit_q <= 4'h0;
					sh_q <= wdata_i;
					pend_q <= 1'b1;
					scl_oe_q <= 1'b1;
					cnt_q <= load_val;
					state_q <= BIT_LOW;
				end
			end
			RS_PULL: begin
				// RULE2: SDA released
				sda_oe_q <= 1'b0;
				// RULE1: load once SCL reads low
				if (!sync_q.scl) begin
					cnt_q <= load_val;
					state_q <= RS_REL;
				end
			end
			RS_REL: begin
				// RULE2: release SCL if SDA high
				if (tick && sync_q.sda) begin
					scl_oe_q <= 1'b0;
					state_q <= RS_SCLH;
				end
			end
			RS_SCLH: begin
				// RULE24: wait for SCL high
				if (sync_q.scl) begin
					if (!sync_q.sda) begin
						// RULE6: SDA low at SCL rise
						scl_oe_q <= 1'b0;
						sda_oe_q <= 1'b0;
						ev_q.bcl <= 1'b1;
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= load_val;
						state_q <= RS_HIGH;
					end
				end
			end
			RS_HIGH: begin
				if (!sync_q.scl) begin
					// RULE6: SCL fell before SDA low
					// RULE25: abort and release
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
					ev_q.bcl <= 1'b1;
					state_q <= ST_IDLE;
				end else if (tick) begin
					// RULE3: SDA low while SCL high
					sda_oe_q <= 1'b1;
					cnt_q <= load_val;
					state_q <= RS_SDAL;
				end
			end
			RS_SDAL: begin
				// RULE3: SCL low, keep SDA low
				// RULE4: irq after timeout
				if (tick) begin
					scl_oe_q <= 1'b1;
					ev_q.rs_done <= 1'b1;
					state_q <= ST_IDLE;
				end
			end
			BIT_LOW: begin
				// RULE8: present bit after falling edge
				if (pend_q) begin
					pend_q <= 1'b0;
					sda_oe_q <= !rx_q && (bit_q != BIT_LAST_TX)
						&& !sh_q[7];
				end
				if (tick) begin
					scl_oe_q <= 1'b0;
					state_q <= BIT_WAIT;
				end
			end
			BIT_WAIT: begin
				// RULE24: counter held while stretched
				if (sync_q.scl) begin
					cnt_q <= load_val;
					state_q <= BIT_HIGH;
					if (rx_q) begin
						// RULE26: one sample, MSB first
						sh_q <= {sh_q[6:0], sync_q.sda};
					end else if (bit_q == BIT_LAST_TX) begin
						// RULE10: capture ack level
						ack_st_q <= sync_q.sda;
					end
				end
			end
			BIT_HIGH: begin
				if (tick) begin
					// RULE15: SCL toggles on rollover
					scl_oe_q <= 1'b1;
					if (rx_q && bit_q == BIT_LAST_RX) begin
						// RULE16: byte done, back to idle
						ev_q.rx_done <= 1'b1;
						state_q <= ST_IDLE;
					end else if (!rx_q && bit_q == BIT_LAST_TX) begin
						// RULE11: hold SCL low, SDA as is
						ev_q.tx_done <= 1'b1;
						state_q <= ST_IDLE;
					end else begin
						// RULE12: next bit per falling edge
						bit_q <= bit_q + 4'h1;
						if (!rx_q) begin
							sh_q <= {sh_q[6:0], 1'b0};
						end
						// RULE9: eighth falling edge
						if (!rx_q && bit_q == BIT_LAST_RX) begin
							ev_q.bf_clr <= 1'b1;
						end
						pend_q <= 1'b1;
						cnt_q <= load_val;
						state_q <= BIT_LOW;
					end
				end
			end
			ACK_LOW: begin
				// RULE20: release SCL after one period
				if (tick) begin
					scl_oe_q <= 1'b0;
					state_q <= ACK_WAIT;
				end
			end
			ACK_WAIT: begin
				if (sync_q.scl) begin
					cnt_q <= load_val;
					state_q <= ACK_HIGH;
				end
			end
			ACK_HIGH: begin
				if (!sda_oe_q && !sync_q.sda) begin
					// RULE25: ack collision, release
					scl_oe_q <= 1'b0;
					ev_q.bcl <= 1'b1;
					state_q <= ST_IDLE;
				end else if (tick) begin
					// RULE20: SCL low, go idle
					scl_oe_q <= 1'b1;
					ev_q.ack_done <= 1'b1;
					state_q <= ST_IDLE;
				end
			end
			default: begin
				scl_oe_q <= 1'b0;
				sda_oe_q <= 1'b0;
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// control requests, hardware clears on completion
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rs_req_q <= 1'b0;
			rx_req_q <= 1'b0;
			ack_req_q <= 1'b0;
			ack_val_q <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				ack_val_q <= wdata_i[CTRL_ACKV_BIT];
			end
			// RULE3: restart request self-clears
			if (go_rs) begin
				rs_req_q <= 1'b1;
			end else if (ev_q.rs_done || ev_q.bcl) begin
				rs_req_q <= 1'b0;
			end
			// RULE16: receive request self-clears
			if (go_rx) begin
				rx_req_q <= 1'b1;
			end else if (ev_q.rx_done) begin
				rx_req_q <= 1'b0;
			end
			// RULE25: requests cleared on collision
			if (go_ack) begin
				ack_req_q <= 1'b1;
			end else if (ev_q.ack_done || ev_q.bcl) begin
				ack_req_q <= 1'b0;
			end
		end
	end

	// buffer and rate registers
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			buf_q <= BYTE_RESET;
			rate_q <= RATE_RESET;
		end else begin
			if (wr_i && addr_i == RATE_OFF) begin
				rate_q <= wdata_i;
			end
			// RULE16: received byte into buffer
			if (ev_q.rx_done) begin
				buf_q <= sh_q;
			end else if (go_tx) begin
				buf_q <= wdata_i;
			end
		end
	end

	// status flags, hardware set wins over software clear
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			bf_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			ov_q <= 1'b0;
			irq_q <= 1'b0;
			bcl_q <= 1'b0;
			begin_q <= 1'b0;
		end else begin
			// RULE7: set on write
			// RULE17: set on receive, cleared by read
			if (go_tx || ev_q.rx_done) begin
				bf_q <= 1'b1;
			end else if (ev_q.bf_clr || buf_rd || ev_q.bcl) begin
				bf_q <= 1'b0;
			end
			// RULE13: write while busy
			if (buf_wr && !idle) begin
				write_collision_flag_q <= 1'b1;
			end else if (stat_wr && wdata_i[STAT_WRITE_COLLISION_FLAG_BIT]) begin
				write_collision_flag_q <= 1'b0;
			end
			// RULE18: byte over a full buffer
			if (ev_q.rx_done && bf_q) begin
				ov_q <= 1'b1;
			end else if (stat_wr && wdata_i[STAT_OV_BIT]) begin
				ov_q <= 1'b0;
			end
			// RULE11 RULE21: irq at step end
			if (ev_q.rs_done || ev_q.tx_done || ev_q.rx_done
				|| ev_q.ack_done) begin
				irq_q <= 1'b1;
			end else if (stat_wr && wdata_i[STAT_IRQ_BIT]) begin
				irq_q <= 1'b0;
			end
			// RULE25: collision flag
			if (ev_q.bcl) begin
				bcl_q <= 1'b1;
			end else if (stat_wr && wdata_i[STAT_BCL_BIT]) begin
				bcl_q <= 1'b0;
			end
			// RULE4: start seen at once
			if (start_seen) begin
				begin_q <= 1'b1;
			end else if (stat_wr && wdata_i[STAT_BEGIN_BIT]) begin
				begin_q <= 1'b0;
			end
		end
	end

	// read port, data valid one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rdata_q <= BYTE_RESET;
		end else if (rd_i) begin
			case (addr_i)
			CTRL_OFF: begin
				rdata_q <= {4'h0, ack_val_q, ack_req_q, rx_req_q,
					rs_req_q};
			end
			STAT_OFF: begin
				rdata_q <= {!idle, ack_st_q, begin_q, bcl_q, irq_q,
					ov_q, write_collision_flag_q, bf_q};
			end
			BUF_OFF: rdata_q <= buf_q;
			RATE_OFF: rdata_q <= rate_q;
			default: begin
				rdata_q <= BYTE_RESET;
			end
			endcase
		end else begin
			rdata_q <= BYTE_RESET;
		end
	end
	assign rdata_o = rdata_q;
endmodule

// File: verilog/i2c_restart_pkg.sv
// constants and types for the i2c master sequencer
// Contract
// RULE1: restart request in idle pulls SCL low; counter loads once SCL reads low.
// RULE2: release SDA one period, then SCL; both lines high one period.
// RULE3: SDA low one period, SCL low, request clears, SDA stays low.
// RULE4: start detection flag sets at once; irq waits for counter timeout.
// RULE5: restart request written while busy is ignored.
// RULE6: SDA low at SCL rise, or SCL falling early, is a collision.
// RULE7: buffer write sets buffer full and starts the counter and transmission.
// RULE8: bit presented after SCL falls; SCL low one period, high one period.
// RULE9: at eighth falling edge clear buffer full and release SDA.
// RULE10: ninth clock level captured as ack status: low clears, high sets.
// RULE11: after ninth clock set irq, hold SCL low until next buffer write.
// RULE12: address sent as seven bits plus direction, then ack sampled.
// RULE13: buffer write while busy sets write collision, buffer unchanged.
// RULE14: receive request honoured only when idle, otherwise disregarded.
// RULE15: accepted receive runs counter, toggles SCL per rollover, shifts SDA in.
// RULE16: after eighth falling edge: copy byte, flags, irq, SCL low, idle.
// RULE17: buffer full sets on received byte, clears on buffer read.
// RULE18: overflow sets when a byte completes while buffer full still set.
// RULE19: ack send pulls SCL low and drives ack value on SDA.
// RULE20: ack: release SCL after period, once high one period, low, idle.
// RULE21: software sequences start, address, data, checks acks, ends transfer.
// RULE22: software receives byte by byte, answering each with ack value.
// RULE23: every counter load takes the low eight bits of rate reload.
// RULE24: counter waits while released SCL is still read low.
// RULE25: collision sets flag, aborts, releases lines, clears request bits.
// RULE26: receive samples SDA once per bit when SCL high, MSB first.
package i2c_restart_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] CTRL_OFF = 4'h0;
	localparam logic [3:0] STAT_OFF = 4'h1;
	localparam logic [3:0] BUF_OFF = 4'h2;
	localparam logic [3:0] RATE_OFF = 4'h3;
	localparam int CTRL_RS_BIT = 0;
	localparam int CTRL_RX_BIT = 1;
	localparam int CTRL_ACK_BIT = 2;
	localparam int CTRL_ACKV_BIT = 3;
	localparam int STAT_BF_BIT = 0;
	localparam int STAT_WRITE_COLLISION_FLAG_BIT = 1;
	localparam int STAT_OV_BIT = 2;
	localparam int STAT_IRQ_BIT = 3;
	localparam int STAT_BCL_BIT = 4;
	localparam int STAT_BEGIN_BIT = 5;
	localparam int STAT_ACKST_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;
	localparam logic [7:0] RATE_RESET = 8'h09;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] BIT_LAST_RX = 4'h7;
	localparam logic [3:0] BIT_LAST_TX = 4'h8;
	typedef struct packed {
		logic rs_done;
		logic tx_done;
		logic rx_done;
		logic ack_done;
		logic bf_clr;
		logic bcl;
	} seq_ev_s;
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_s;
endpackage

// File: test/i2c_master_restart_tx_rx_ack_checker.sv
// port-level assertions for the i2c master sequencer
`timescale 1ns/1ps
module i2c_master_restart_tx_rx_ack_checker
	import i2c_restart_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o
);
	logic [7:0] rate_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// track the reload value written by software
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			rate_q <= RATE_RESET;
		else if (wr_i && addr_i == RATE_OFF)
			rate_q <= wdata_i;
	end
	chk_rate_readback: assert property (
		rd_i && addr_i == RATE_OFF |=> rdata_o == rate_q)
		else $error("rate register read back wrong");
	chk_rdata_quiet: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside read");
	chk_low_phase: assert property (
		$rose(scl_oe_o) |-> scl_oe_o [*8])
		else $error("clock low phase too short");
	chk_high_phase: assert property (
		$fell(scl_oe_o) |-> !scl_oe_o [*8])
		else $error("clock high phase too short");
	chk_sda_release: assert property (
		$fell(sda_oe_o) |-> scl_oe_o)
		else $error("data released while clock high");
	chk_start_shape: assert property (
		$rose(sda_oe_o) && !scl_oe_o |->
		(sda_oe_o && !scl_oe_o) [*8] ##[1:40] (sda_oe_o && scl_oe_o))
		else $error("repeated start shape wrong");
	chk_stretch_wait: assert property (
		!scl_oe_o && !scl_i |=> !scl_oe_o)
		else $error("clock pulled while stretched");
	chk_drive_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("open drain output not low");
	cover property ($rose(scl_oe_o));
	cover property ($rose(sda_oe_o) && !scl_oe_o);
	cover property (rd_i && addr_i == RATE_OFF);
endmodule

bind i2c_master_restart_tx_rx_ack i2c_master_restart_tx_rx_ack_checker chk (.*);

// File: test/i2c_slave_model.sv
// bus-side slave model: acks, sends a byte, stretches clock
`timescale 1ns/1ps
module i2c_slave_model (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic rd_mode_i,
	input wire logic ack_i,
	input wire logic stretch_i,
	input wire logic [7:0] tx_byte_i,
	output logic scl_pull_o,
	output logic sda_pull_o,
	output logic [7:0] rx_byte_o,
	output logic ack_seen_o
);
	int cnt = 0;
	int ph = 0;
	initial scl_pull_o = 1'b0;
	// start condition restarts count
	always @(negedge sda_i) begin
		if (scl_i === 1'b1)
			cnt = 0;
	end
	always @(posedge scl_i) begin
		if (cnt < 8)
			rx_byte_o = {rx_byte_o[6:0], sda_i};
		if (cnt == 8)
			ack_seen_o = sda_i;
		cnt = cnt + 1;
	end
	always @(negedge scl_i) begin
		if (cnt >= 9)
			cnt = 0;
		ph = cnt;
	end
	assign sda_pull_o = rd_mode_i ? (ph < 8 && !tx_byte_i[3'(7 - ph)]) :
		(ph == 8 && ack_i);
	always @(negedge scl_i) begin
		if (stretch_i) begin
			scl_pull_o = 1'b1;
			#200 scl_pull_o = 1'b0;
		end
	end
endmodule

// File: test/i2c_master_restart_tx_rx_ack_bench.sv
// self-checking bench for the i2c master sequencer
`timescale 1ns/1ps
module i2c_master_restart_tx_rx_ack_bench;
	import i2c_restart_pkg::*;
	typedef struct {
		logic w;
		logic [3:0] a;
		logic [7:0] d;
	} row_s;
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic rd_mode = 1'h0;
	logic ack = 1'h1;
	logic stretch = 1'h0;
	logic [7:0] rdata, got, rx_byte;
	logic scl_oe, sda_oe, s_scl, s_sda, ack_seen;
	int mismatches = 0;
	int checks_done = 0;
	wire scl_w = !(scl_oe || s_scl);
	wire sda_w = !(sda_oe || s_sda);
	row_s rows[8] = '{
		'{1'h0, CTRL_OFF, 8'h00}, '{1'h0, STAT_OFF, 8'h00},
		'{1'h0, BUF_OFF, BYTE_RESET}, '{1'h0, RATE_OFF, RATE_RESET},
		'{1'h1, RATE_OFF, 8'h5a}, '{1'h0, RATE_OFF, 8'h5a},
		'{1'h0, 4'h9, 8'h00}, '{1'h1, RATE_OFF, RATE_RESET}};
	always #5 clk_i = ~clk_i;
	i2c_master_restart_tx_rx_ack dut (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.addr_i(addr),
		.wdata_i(wdata),
		.wr_i(wr),
		.rd_i(rd),
		.rdata_o(rdata),
		.scl_i(scl_w),
		.scl_o(),
		.scl_oe_o(scl_oe),
		.sda_i(sda_w),
		.sda_o(),
		.sda_oe_o(sda_oe)
	);
	i2c_slave_model slave (
		.scl_i(scl_w),
		.sda_i(sda_w),
		.rd_mode_i(rd_mode),
		.ack_i(ack),
		.stretch_i(stretch),
		.tx_byte_i(8'h5c),
		.scl_pull_o(s_scl),
		.sda_pull_o(s_sda),
		.rx_byte_o(rx_byte),
		.ack_seen_o(ack_seen)
	);
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk_i);
		wr <= 1'h0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk_i);
		rd <= 1'h0;
		@(negedge clk_i);
		got = rdata;
	endtask
	task automatic poll(input logic [3:0] a, input int b);
		int k;
		k = 0;
		rreg(a);
		while (got[b] !== 1'h0 && k < 400) begin
			rreg(a);
			k++;
		end
		chk("poll", {7'h00, got[b]}, 8'h00);
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].w)
				wreg(rows[i].a, rows[i].d);
			else begin
				rreg(rows[i].a);
				chk("row", got, rows[i].d);
			end
		end
		wreg(CTRL_OFF, 8'h01);
		poll(CTRL_OFF, CTRL_RS_BIT);
		rreg(STAT_OFF);
		chk("rs stat", got, 8'h28);
		chk("rs lines", {6'h00, scl_w, sda_w}, 8'h00);
		wreg(STAT_OFF, 8'h3e);
		wreg(BUF_OFF, 8'ha6);
		rreg(STAT_OFF);
		chk("tx stat", got, 8'h81);
		wreg(BUF_OFF, 8'hff);
		wreg(CTRL_OFF, 8'h03);
		rreg(STAT_OFF);
		chk("write_collision_flag", got, 8'h83);
		rreg(CTRL_OFF);
		chk("busy ctrl", got, 8'h00);
		wreg(STAT_OFF, 8'h02);
		poll(STAT_OFF, STAT_BUSY_BIT);
		rreg(STAT_OFF);
		chk("ack stat", got, 8'h08);
		chk("tx byte", rx_byte, 8'ha6);
		chk("scl held", {7'h00, scl_w}, 8'h00);
		ack = 1'h0;
		wreg(STAT_OFF, 8'h08);
		wreg(BUF_OFF, 8'h3c);
		poll(STAT_OFF, STAT_BUSY_BIT);
		rreg(STAT_OFF);
		chk("nack stat", got, 8'h48);
		chk("tx byte", rx_byte, 8'h3c);
		wreg(STAT_OFF, 8'h08);
		rd_mode = 1'h1;
		stretch = 1'h1;
		wreg(CTRL_OFF, 8'h02);
		poll(CTRL_OFF, CTRL_RX_BIT);
		rreg(STAT_OFF);
		chk("rx stat", got, 8'h49);
		wreg(CTRL_OFF, 8'h00);
		wreg(CTRL_OFF, 8'h04);
		poll(CTRL_OFF, CTRL_ACK_BIT);
		chk("ack out", {7'h00, ack_seen}, 8'h00);
		wreg(STAT_OFF, 8'h08);
		wreg(CTRL_OFF, 8'h02);
		poll(CTRL_OFF, CTRL_RX_BIT);
		rreg(STAT_OFF);
		chk("overflow", got, 8'h4d);
		rreg(BUF_OFF);
		chk("rx byte", got, 8'h5c);
		rreg(STAT_OFF);
		chk("bf read", got, 8'h4c);
		wreg(CTRL_OFF, 8'h08);
		wreg(CTRL_OFF, 8'h0c);
		poll(CTRL_OFF, CTRL_ACK_BIT);
		chk("nack out", {7'h00, ack_seen}, 8'h01);
		wreg(STAT_OFF, 8'h08);
		wreg(CTRL_OFF, 8'h0c);
		poll(CTRL_OFF, CTRL_ACK_BIT);
		rreg(STAT_OFF);
		chk("ack collision", got, 8'h54);
		rreg(CTRL_OFF);
		chk("ack cleared", got, 8'h08);
		chk("lines freed", {6'h00, scl_w, sda_w}, 8'h02);
		report_and_stop();
	end
endmodule
